// file: rtl/procbus_pkg.sv
// Constants, encodings and types shared by the processor bus master port.
// Assumes one core clock; the far end is bus slave logic on that clock.
// What this block does
// - Request fields mean something only while request valid is high.
// - Drive an 8-bit request control: transaction type and block size.
// - Request address is always aligned to the transfer size.
// - Write data rides writes, block writes and conditional writes.
// - Data path width is a parameter: 32, 64 or 128 bits.
// - One byte enable per data byte, for writes and for expected read lanes.
// - Every request carries a 6-bit tag returned with its response.
// - Drive a 2-bit request priority, 0x0 lowest, 0x3 highest.
// - A request moves only when request valid and ready are both high.
// - Response fields mean something only while response valid is high.
// - Response data width equals request data width.
// - A response beat moves only when its valid and ready are both high.
package procbus_pkg;

  localparam int ADDR_W = 32;
  localparam int CTL_W = 8;
  localparam int TAG_W = 6;
  localparam int PRIO_W = 2;
  localparam int DEFAULT_DATA_W = 32;
  localparam int NUM_TAGS = 64;
  localparam int CNT_W = 7;
  localparam int FIFO_DEPTH = 16;
  localparam int BEAT_W = 5;
  localparam int SIZE_W = 4;

  // Control byte layout: type in the high nibble, size code in the low one
  localparam int CTL_TYPE_LSB = 4;
  localparam int CTL_SIZE_LSB = 0;
  localparam int RSP_LAST_BIT = 0;
  localparam int MAX_BLOCK_LOG = 4;

  localparam logic [1:0] PRIO_LOW = 2'h0;
  localparam logic [1:0] PRIO_HIGH = 2'h3;
  localparam logic [CNT_W-1:0] OUTSTANDING_RESET = 7'h00;

  typedef enum logic [3:0] {
    REQ_READ = 4'h1,
    REQ_WRITE = 4'h2,
    REQ_BLOCK_READ = 4'h3,
    REQ_BLOCK_WRITE = 4'h4,
    REQ_COND_WRITE = 4'h5
  } req_type_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BURST = 2'b10
  } fsm_state_t;

endpackage

// file: rtl/procbus_rsp_fifo.sv
// Response buffer: parameterised width and depth, valid/ready both sides.
// Assumes the writer respects in_ready_o; a push while full is dropped.
`timescale 1ns/1ps
module procbus_rsp_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = procbus_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] count_o
);
  import procbus_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
  } fifo_st_t;

  fifo_st_t st_reg;
  fifo_st_t st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready_o = (st_reg.count != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (st_reg.count != '0);
  assign out_data_o = mem[st_reg.rd_ptr];
  assign count_o = st_reg.count;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  // Storage has no reset; only the pointers and count define what is valid
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[st_reg.wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// file: rtl/procbus_tag_pool.sv
// Pool of request tags: hands out the lowest free tag, takes tags back.
// Assumes a tag is only released while it is in use.
`timescale 1ns/1ps
module procbus_tag_pool (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic alloc_i,
  output logic [procbus_pkg::TAG_W-1:0] tag_o,
  output logic avail_o,
  input wire logic release_i,
  input wire logic [procbus_pkg::TAG_W-1:0] release_tag_i,
  output logic [procbus_pkg::CNT_W-1:0] free_cnt_o
);
  import procbus_pkg::*;

  typedef struct packed {
    logic [NUM_TAGS-1:0] free;
    logic [CNT_W-1:0] free_cnt;
  } pool_st_t;

  pool_st_t st_reg;
  pool_st_t st_next;

  assign avail_o = |st_reg.free;
  assign free_cnt_o = st_reg.free_cnt;

  always_comb begin
    tag_o = '0;
    for (int i = NUM_TAGS - 1; i >= 0; i--) begin
      if (st_reg.free[i]) begin
        tag_o = TAG_W'(i);
      end
    end
  end

  always_comb begin
    st_next = st_reg;
    // Tags are reused without ordering; the slave must cope
    if (alloc_i && avail_o) begin
      st_next.free[tag_o] = 1'b0;
    end
    if (release_i) begin
      st_next.free[release_tag_i] = 1'b1;
    end
    if ((alloc_i && avail_o) && !release_i) begin
      st_next.free_cnt = st_reg.free_cnt - 1'b1;
    end else if (release_i && !(alloc_i && avail_o)) begin
      st_next.free_cnt = st_reg.free_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg.free <= '1;
      st_reg.free_cnt <= CNT_W'(NUM_TAGS);
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// file: rtl/procbus_master_port.sv
// Master end of the processor system bus: takes core requests, tags them,
// checks alignment, drives the bus request and buffers tagged responses.
// Assumes the slave answers every tagged request with a last-marked beat.
`timescale 1ns/1ps
module procbus_master_port #(
  parameter int DATA_W = procbus_pkg::DEFAULT_DATA_W,
  parameter int RSP_DEPTH = procbus_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic cpu_req_valid_i,
  output logic cpu_req_ready_o,
  input wire procbus_pkg::req_type_t cpu_req_type_i,
  input wire logic [procbus_pkg::SIZE_W-1:0] cpu_req_size_i,
  input wire logic [procbus_pkg::ADDR_W-1:0] cpu_req_addr_i,
  input wire logic [DATA_W-1:0] cpu_req_wdata_i,
  input wire logic [procbus_pkg::PRIO_W-1:0] cpu_req_prio_i,
  output logic cpu_req_error_o,
  output logic cpu_rsp_valid_o,
  input wire logic cpu_rsp_ready_i,
  output logic [procbus_pkg::CTL_W-1:0] cpu_rsp_control_o,
  output logic [DATA_W-1:0] cpu_rsp_rdata_o,
  output logic [procbus_pkg::TAG_W-1:0] cpu_rsp_tag_o,
  output logic [procbus_pkg::PRIO_W-1:0] cpu_rsp_prio_o,
  output logic [procbus_pkg::CNT_W-1:0] outstanding_o,
  output logic req_valid_out_o,
  output logic [procbus_pkg::CTL_W-1:0] req_control_out_o,
  output logic [procbus_pkg::ADDR_W-1:0] req_addr_out_o,
  output logic [DATA_W-1:0] req_wdata_out_o,
  output logic [DATA_W/8-1:0] req_byte_en_out_o,
  output logic [procbus_pkg::TAG_W-1:0] req_tag_out_o,
  output logic [procbus_pkg::PRIO_W-1:0] req_prio_out_o,
  input wire logic req_ready_in_i,
  input wire logic rsp_valid_in_i,
  input wire logic [procbus_pkg::CTL_W-1:0] rsp_control_in_i,
  input wire logic [DATA_W-1:0] rsp_rdata_in_i,
  input wire logic [procbus_pkg::TAG_W-1:0] rsp_tag_in_i,
  input wire logic [procbus_pkg::PRIO_W-1:0] rsp_prio_in_i,
  output logic rsp_ready_out_o
);
  import procbus_pkg::*;

  localparam int LANES = DATA_W / 8;
  localparam int LANE_W = $clog2(LANES);
  localparam int RSP_W = CTL_W + DATA_W + TAG_W + PRIO_W;
  localparam int FCNT_W = $clog2(RSP_DEPTH) + 1;

  // One response beat, packed as it sits in the buffer
  typedef struct packed {
    logic [CTL_W-1:0] ctl;
    logic [DATA_W-1:0] data;
    logic [TAG_W-1:0] tag;
    logic [PRIO_W-1:0] prio;
  } rsp_word_t;

  typedef struct packed {
    fsm_state_t state;
    logic [BEAT_W-1:0] beats_left;
    logic cpu_ready;
    logic cpu_error;
    logic req_valid;
    logic [CTL_W-1:0] req_ctl;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_wdata;
    logic [LANES-1:0] req_be;
    logic [TAG_W-1:0] req_tag;
    logic [PRIO_W-1:0] req_prio;
    logic rsp_ready;
    logic rsp_valid;
    rsp_word_t rsp_word;
    logic [CNT_W-1:0] outstanding;
  } port_st_t;

  port_st_t st_reg;
  port_st_t st_next;

  logic [TAG_W-1:0] pool_tag;
  logic pool_avail;
  logic pool_alloc;
  logic [CNT_W-1:0] pool_free;
  logic rsp_fire;
  logic rsp_last;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [RSP_W-1:0] fifo_out_data;
  logic [FCNT_W-1:0] fifo_count;
  logic [FCNT_W-1:0] fifo_count_next;
  rsp_word_t rsp_in_word;

  // Request decode of the current core request
  logic cpu_take;
  logic is_block;
  logic has_data;
  logic [SIZE_W:0] bytes_log;
  logic bad_size;
  logic misaligned;
  logic [ADDR_W-1:0] align_mask;
  logic [LANES-1:0] lane_mask;
  logic [BEAT_W-1:0] block_beats;
  logic slot_free;

  // Beats move only on valid with ready
  assign rsp_fire = rsp_valid_in_i && st_reg.rsp_ready && fifo_in_ready;
  assign rsp_last = rsp_control_in_i[RSP_LAST_BIT];

  // Incoming beat as it is buffered
  always_comb begin
    rsp_in_word.ctl = rsp_control_in_i;
    rsp_in_word.data = rsp_rdata_in_i;
    rsp_in_word.tag = rsp_tag_in_i;
    rsp_in_word.prio = rsp_prio_in_i;
  end

  // Unknown type codes pass as plain singles that carry no data
  always_comb begin
    is_block = 1'b0;
    has_data = 1'b0;
    case (cpu_req_type_i)
      REQ_WRITE: begin
        has_data = 1'b1;
      end
      REQ_COND_WRITE: begin
        has_data = 1'b1;
      end
      REQ_BLOCK_READ: begin
        is_block = 1'b1;
      end
      REQ_BLOCK_WRITE: begin
        is_block = 1'b1;
        has_data = 1'b1;
      end
      default: begin
        is_block = 1'b0;
        has_data = 1'b0;
      end
    endcase
  end
  assign block_beats = BEAT_W'(1) << cpu_req_size_i;

  always_comb begin
    bad_size = 1'b0;
    bytes_log = {1'b0, cpu_req_size_i};
    if (is_block) begin
      bytes_log = (SIZE_W+1)'(LANE_W) + {1'b0, cpu_req_size_i};
      bad_size = (cpu_req_size_i == '0) ||
                 (cpu_req_size_i > SIZE_W'(MAX_BLOCK_LOG));
    end else begin
      bad_size = (cpu_req_size_i > SIZE_W'(LANE_W));
    end
  end

  // Transfer-size alignment is enforced, never passed on
  assign align_mask = (ADDR_W'(1) << bytes_log) - ADDR_W'(1);
  assign misaligned = |(cpu_req_addr_i & align_mask);

  // Lane enables: all lanes for blocks, size window at offset otherwise
  always_comb begin
    lane_mask = '0;
    for (int i = 0; i < LANES; i++) begin
      if (is_block) begin
        lane_mask[i] = 1'b1;
      end else begin
        lane_mask[i] = (i >= int'(cpu_req_addr_i[LANE_W-1:0])) &&
          (i < int'(cpu_req_addr_i[LANE_W-1:0]) +
               (1 << cpu_req_size_i));
      end
    end
  end

  assign cpu_take = cpu_req_valid_i && st_reg.cpu_ready;
  // A tag is drawn only for the first beat of a fresh transaction
  assign pool_alloc = cpu_take && (st_reg.state == ST_IDLE) &&
                      !bad_size && !misaligned;

  always_comb begin
    st_next = st_reg;
    st_next.cpu_error = 1'b0;
    slot_free = 1'b0;

    // Hold the request until the slave takes it
    if (st_reg.req_valid && req_ready_in_i) begin
      st_next.req_valid = 1'b0;
    end

    if (cpu_take) begin
      unique case (st_reg.state)
        ST_IDLE: begin
          if (bad_size || misaligned) begin
            st_next.cpu_error = 1'b1;
          end else begin
            st_next.req_valid = 1'b1;
            st_next.req_ctl = {cpu_req_type_i, cpu_req_size_i};
            st_next.req_addr = cpu_req_addr_i;
            st_next.req_be = lane_mask;
            st_next.req_tag = pool_tag;
            st_next.req_prio = cpu_req_prio_i;
            // Reads carry zeros so a snooping slave sees no stale data
            st_next.req_wdata = has_data ? cpu_req_wdata_i : '0;
            if (cpu_req_type_i == REQ_BLOCK_WRITE) begin
              st_next.state = ST_BURST;
              st_next.beats_left = block_beats - BEAT_W'(1);
            end
          end
        end
        ST_BURST: begin
          // Later beats reuse the latched control, address and tag
          st_next.req_valid = 1'b1;
          st_next.req_wdata = cpu_req_wdata_i;
          st_next.beats_left = st_reg.beats_left - BEAT_W'(1);
          if (st_reg.beats_left == BEAT_W'(1)) begin
            st_next.state = ST_IDLE;
          end
        end
      endcase
    end

    // Core may offer again once the bus slot empties; costs one idle cycle
    slot_free = !st_next.req_valid;
    if (st_next.state == ST_BURST) begin
      st_next.cpu_ready = slot_free && !cpu_take;
    end else begin
      // Free count lags an allocation by a cycle, so keep one tag spare
      st_next.cpu_ready = slot_free && !cpu_take && pool_avail &&
                          (pool_free > CNT_W'(1));
    end

    // Response path: ready from the flop keeps a one-entry margin
    fifo_count_next = fifo_count;
    if (rsp_fire && !(fifo_out_valid && fifo_out_ready)) begin
      fifo_count_next = fifo_count + FCNT_W'(1);
    end else if (!rsp_fire && fifo_out_valid && fifo_out_ready) begin
      fifo_count_next = fifo_count - FCNT_W'(1);
    end
    st_next.rsp_ready = fifo_count_next <= FCNT_W'(RSP_DEPTH - 2);

    // Core-facing response stage
    if (fifo_out_ready) begin
      st_next.rsp_valid = fifo_out_valid;
      if (fifo_out_valid) begin
        st_next.rsp_word = rsp_word_t'(fifo_out_data);
      end
    end

    st_next.outstanding = CNT_W'(NUM_TAGS) - pool_free;
  end

  assign fifo_out_ready = !st_reg.rsp_valid || cpu_rsp_ready_i;

  procbus_tag_pool u_tag_pool (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .alloc_i(pool_alloc),
    .tag_o(pool_tag),
    .avail_o(pool_avail),
    .release_i(rsp_fire && rsp_last),
    .release_tag_i(rsp_tag_in_i),
    .free_cnt_o(pool_free)
  );

  // Fields are sampled only on a qualified beat
  procbus_rsp_fifo #(
    .WIDTH(RSP_W),
    .DEPTH(RSP_DEPTH)
  ) u_rsp_fifo (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(rsp_valid_in_i && st_reg.rsp_ready),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rsp_in_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data),
    .count_o(fifo_count)
  );

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.req_prio <= PRIO_LOW;
      st_reg.outstanding <= OUTSTANDING_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cpu_req_ready_o = st_reg.cpu_ready;
  assign cpu_req_error_o = st_reg.cpu_error;
  assign cpu_rsp_valid_o = st_reg.rsp_valid;
  assign cpu_rsp_control_o = st_reg.rsp_word.ctl;
  assign cpu_rsp_rdata_o = st_reg.rsp_word.data;
  assign cpu_rsp_tag_o = st_reg.rsp_word.tag;
  assign cpu_rsp_prio_o = st_reg.rsp_word.prio;
  assign outstanding_o = st_reg.outstanding;
  assign req_valid_out_o = st_reg.req_valid;
  assign req_control_out_o = st_reg.req_ctl;
  assign req_addr_out_o = st_reg.req_addr;
  assign req_wdata_out_o = st_reg.req_wdata;
  assign req_byte_en_out_o = st_reg.req_be;
  assign req_tag_out_o = st_reg.req_tag;
  assign req_prio_out_o = st_reg.req_prio;
  assign rsp_ready_out_o = st_reg.rsp_ready;

endmodule

// file: dv/procbus_master_port_checker.sv
// Protocol checker for the bus master port, bound to its top ports.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module procbus_master_port_checker #(
  parameter int DATA_W = 32
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic cpu_req_valid_i,
  input wire logic cpu_req_ready_o,
  input wire logic cpu_req_error_o,
  input wire logic cpu_rsp_valid_o,
  input wire logic cpu_rsp_ready_i,
  input wire logic [DATA_W-1:0] cpu_rsp_rdata_o,
  input wire logic [5:0] cpu_rsp_tag_o,
  input wire logic [1:0] cpu_rsp_prio_o,
  input wire logic req_valid_out_o,
  input wire logic [7:0] req_control_out_o,
  input wire logic [31:0] req_addr_out_o,
  input wire logic [DATA_W-1:0] req_wdata_out_o,
  input wire logic [DATA_W/8-1:0] req_byte_en_out_o,
  input wire logic [5:0] req_tag_out_o,
  input wire logic [1:0] req_prio_out_o,
  input wire logic req_ready_in_i
);
  logic [31:0] amask;
  logic [3:0] rtype;
  logic blk;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  assign rtype = req_control_out_o[7:4];
  assign blk = rtype == 4'h3 || rtype == 4'h4;
  // Block spans all lanes times beats; single spans 2^size bytes
  assign amask = blk ? (32'(DATA_W / 8) << req_control_out_o[3:0]) - 32'h1
                     : (32'h1 << req_control_out_o[3:0]) - 32'h1;
  chk_req_hold:
  assert property (req_valid_out_o && !req_ready_in_i |=> req_valid_out_o
    && $stable({req_control_out_o, req_addr_out_o, req_wdata_out_o,
    req_byte_en_out_o, req_tag_out_o, req_prio_out_o}))
    else $error("bus request changed while waiting");
  chk_take_answer:
  assert property (cpu_req_valid_i && cpu_req_ready_o
    |=> req_valid_out_o ^ cpu_req_error_o) else $error("take not answered");
  chk_take_gap:
  assert property (cpu_req_valid_i && cpu_req_ready_o |=> !cpu_req_ready_o)
    else $error("core ready high after take");
  chk_bus_release:
  assert property (req_valid_out_o && req_ready_in_i |=> !req_valid_out_o)
    else $error("bus valid kept after transfer");
  chk_addr_align:
  assert property (req_valid_out_o |-> (req_addr_out_o & amask) == 32'h0)
    else $error("bus address not aligned");
  chk_read_nodata:
  assert property (req_valid_out_o && (rtype == 4'h1 || rtype == 4'h3)
    |-> req_wdata_out_o == '0) else $error("read carries data");
  chk_block_lanes:
  assert property (req_valid_out_o && blk |-> &req_byte_en_out_o)
    else $error("block request lacks lanes");
  chk_refuse_quiet:
  assert property (cpu_req_error_o |-> !req_valid_out_o ##1 !cpu_req_error_o)
    else $error("refusal not clean");
  chk_rsp_hold:
  assert property (cpu_rsp_valid_o && !cpu_rsp_ready_i |=> cpu_rsp_valid_o
    && $stable({cpu_rsp_rdata_o, cpu_rsp_tag_o, cpu_rsp_prio_o}))
    else $error("core response changed while waiting");
endmodule

// file: dv/procbus_slave_model.sv
// Bus slave model: takes tagged requests, answers them in order.
// Assumes block write beats arrive in order, one block at a time.
`timescale 1ns/1ps
module procbus_slave_model (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic slow_i,
  input wire logic req_valid_i,
  input wire logic [7:0] req_ctl_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [5:0] req_tag_i,
  input wire logic [1:0] req_prio_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_ctl_o,
  output logic [31:0] rsp_data_o,
  output logic [5:0] rsp_tag_o,
  output logic [1:0] rsp_prio_o,
  input wire logic rsp_ready_i
);
  logic [47:0] pend[$];
  logic [47:0] h;
  int wcnt = 0;
  int k = 0;
  initial begin
    {req_ready_o, rsp_valid_o, rsp_ctl_o, rsp_data_o} = '0;
    {rsp_tag_o, rsp_prio_o} = '0;
  end
  always @(posedge core_clk_i) begin
    if (req_valid_i && req_ready_o) begin
      wcnt = req_ctl_i[7:4] == 4'h4 ? wcnt + 1 : 0;
      // Tags kept as given: no uniqueness assumed
      if (wcnt == 0 || wcnt == 1 << req_ctl_i[3:0]) begin
        pend.push_back({req_tag_i, req_prio_i, req_addr_i,
          req_ctl_i[7:4] == 4'h3 ? 8'h1 << req_ctl_i[3:0] : 8'h1});
        wcnt = 0;
      end
    end
    if (rsp_valid_o && rsp_ready_i) begin
      k++;
      if (rsp_ctl_o[0]) begin
        void'(pend.pop_front());
        k = 0;
      end
    end
    if (!reset_n_i)
      pend.delete();
    #1;
    req_ready_o = !slow_i || $urandom % 3 == 0;
    // Once raised, valid holds until taken
    rsp_valid_o = pend.size() > 0
      && (!slow_i || rsp_valid_o || $urandom % 2 == 0);
    if (rsp_valid_o) begin
      h = pend[0];
      rsp_tag_o = h[47:42];
      rsp_prio_o = h[41:40];
      rsp_data_o = ~h[39:8] + 32'(k);
      rsp_ctl_o = {7'h0, 8'(k + 1) == h[7:0]};
    end else
      {rsp_data_o, rsp_tag_o, rsp_prio_o, rsp_ctl_o} =
        ~{rsp_data_o, rsp_tag_o, rsp_prio_o, rsp_ctl_o};
  end
endmodule

// file: dv/procbus_master_port_test.sv
// Bench for the bus master port: core driver, slave model, monitors.
// Driver queues expected traffic; negedge monitors pop and compare.
`timescale 1ns/1ps
module procbus_master_port_test;
  import procbus_pkg::*;
  logic core_clk_i, reset_n_i, cpu_req_valid_i, cpu_req_ready_o;
  logic cpu_req_error_o, cpu_rsp_valid_o, req_valid_out_o, req_ready_in_i;
  logic rsp_valid_in_i, rsp_ready_out_o, slow;
  logic cpu_rsp_ready_i = 1'b1;
  req_type_t cpu_req_type_i;
  logic [3:0] cpu_req_size_i, req_byte_en_out_o, sz;
  logic [1:0] cpu_req_prio_i, cpu_rsp_prio_o, req_prio_out_o, rsp_prio_in_i;
  logic [5:0] cpu_rsp_tag_o, req_tag_out_o, rsp_tag_in_i;
  logic [6:0] outstanding_o;
  logic [7:0] cpu_rsp_control_o, req_control_out_o, rsp_control_in_i;
  logic [31:0] cpu_req_addr_i, cpu_req_wdata_i, cpu_rsp_rdata_o;
  logic [31:0] req_addr_out_o, req_wdata_out_o, rsp_rdata_in_i;
  logic [77:0] busq[$];
  logic [40:0] rspq[$];
  bit errq[$];
  logic [3:0] sgl[3] = '{4'h1, 4'h2, 4'h5};
  int bad_count = 0;
  int n_checks = 0;
  int mode = 1;
  procbus_master_port i_dut (
    .core_clk_i, .reset_n_i, .cpu_req_valid_i, .cpu_req_ready_o,
    .cpu_req_type_i, .cpu_req_size_i, .cpu_req_addr_i, .cpu_req_wdata_i,
    .cpu_req_prio_i, .cpu_req_error_o, .cpu_rsp_valid_o, .cpu_rsp_ready_i,
    .cpu_rsp_control_o, .cpu_rsp_rdata_o, .cpu_rsp_tag_o, .cpu_rsp_prio_o,
    .outstanding_o, .req_valid_out_o, .req_control_out_o, .req_addr_out_o,
    .req_wdata_out_o, .req_byte_en_out_o, .req_tag_out_o, .req_prio_out_o,
    .req_ready_in_i, .rsp_valid_in_i, .rsp_control_in_i, .rsp_rdata_in_i,
    .rsp_tag_in_i, .rsp_prio_in_i, .rsp_ready_out_o);
  procbus_slave_model i_slave (.core_clk_i, .reset_n_i, .slow_i(slow),
    .req_valid_i(req_valid_out_o), .req_ctl_i(req_control_out_o),
    .req_addr_i(req_addr_out_o), .req_tag_i(req_tag_out_o),
    .req_prio_i(req_prio_out_o), .req_ready_o(req_ready_in_i),
    .rsp_valid_o(rsp_valid_in_i), .rsp_ctl_o(rsp_control_in_i),
    .rsp_data_o(rsp_rdata_in_i), .rsp_tag_o(rsp_tag_in_i),
    .rsp_prio_o(rsp_prio_in_i), .rsp_ready_i(rsp_ready_out_o));
  initial begin
    core_clk_i = 0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  task automatic chk(string nm, logic [77:0] s, logic [77:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick();
    @(posedge core_clk_i) #1;
  endtask
  // Monitors sample at the falling edge, clear of launch races
  always @(negedge core_clk_i) begin
    if (req_valid_out_o && req_ready_in_i)
      chk("bus", {req_control_out_o, req_addr_out_o, req_wdata_out_o,
      req_byte_en_out_o, req_prio_out_o}, busq.pop_front());
    if (cpu_rsp_valid_o && cpu_rsp_ready_i)
      chk("rsp", {cpu_rsp_tag_o, cpu_rsp_prio_o, cpu_rsp_rdata_o,
        cpu_rsp_control_o[0]}, rspq.pop_front());
    if (cpu_req_error_o)
      chk("refusal", 1, errq.pop_front());
  end
  always @(posedge core_clk_i) begin
    #1;
    cpu_rsp_ready_i = mode == 2 ? $urandom % 4 != 0 : mode == 1;
  end
  task automatic req(logic [3:0] t, logic [3:0] s, logic [31:0] a, bit bad);
    logic [31:0] d;
    logic [4:0] m;
    logic [3:0] be;
    logic [1:0] p;
    logic [5:0] tg;
    int nb;
    p = 2'($urandom);
    m = (5'h1 << (5'h1 << s[1:0])) - 5'h1;
    be = (t == 4'h3 || t == 4'h4) ? 4'hf : m[3:0] << a[1:0];
    nb = (t == 4'h4 && !bad) ? 1 << s : 1;
    for (int k = 0; k < nb; k++) begin
      d = $urandom;
      if (bad)
        errq.push_back(1'b1);
      else
        busq.push_back({t, s, a, (t == 4'h1 || t == 4'h3) ? 32'h0 : d, be, p});
      tick();
      cpu_req_type_i = req_type_t'(t);
      {cpu_req_valid_i, cpu_req_size_i, cpu_req_addr_i} = {1'b1, s, a};
      {cpu_req_wdata_i, cpu_req_prio_i} = {d, p};
      for (int n = 0; n < 500 && cpu_req_ready_o !== 1'b1; n++)
        tick();
      if (cpu_req_ready_o !== 1'b1)
        chk("core ready", cpu_req_ready_o, 1);
      tick();
      if (k == 0)
        tg = req_tag_out_o;
      cpu_req_valid_i = 0;
    end
    nb = (t == 4'h3) ? 1 << s : 1;
    for (int k = 0; k < nb && !bad; k++)
      rspq.push_back({tg, p, ~a + 32'(k), k == nb - 1});
  endtask
  initial begin
    {reset_n_i, cpu_req_valid_i, slow, cpu_req_size_i} = '0;
    {cpu_req_addr_i, cpu_req_wdata_i, cpu_req_prio_i} = '0;
    cpu_req_type_i = REQ_READ;
    void'($urandom(34));
    repeat (10) @(posedge core_clk_i);
    #1;
    reset_n_i = 1;
    mode = 2;
    for (int i = 0; i < 18; i++) begin
      slow = i >= 9;
      sz = 4'((i / 3) % 3);
      req(sgl[i % 3], sz, $urandom << sz, 0);
    end
    $display("test singles done");
    for (int c = 1; c < 5; c++) begin
      sz = 4'(c);
      req(4'h3, sz, $urandom << (c + 2), 0);
      req(4'h4, sz, $urandom << (c + 2), 0);
    end
    $display("test blocks done");
    req(4'h2, 4'h1, 32'h1001, 1);
    req(4'h1, 4'h3, 32'h0, 1);
    req(4'h3, 4'h0, 32'h0, 1);
    req(4'h4, 4'h5, 32'h0, 1);
    req(4'h3, 4'h1, 32'h4, 1);
    $display("test refusals done");
    mode = 0;
    slow = 0;
    repeat (20) req(4'h1, 4'h2, $urandom << 2, 0);
    repeat (30) tick();
    chk("rsp ready", rsp_ready_out_o, 0);
    mode = 1;
    repeat (200) tick();
    chk("left", busq.size() + rspq.size() + errq.size(), 0);
    chk("outstanding", outstanding_o, 0);
    $display("test buffer fill done");
    test_done();
  end
  initial begin
    #400000;
    bad_count++;
    test_done();
  end
endmodule
bind procbus_master_port procbus_master_port_checker #(.DATA_W(DATA_W))
  i_chk (.core_clk_i, .reset_n_i, .cpu_req_valid_i, .cpu_req_ready_o,
  .cpu_req_error_o, .cpu_rsp_valid_o, .cpu_rsp_ready_i, .cpu_rsp_rdata_o,
  .cpu_rsp_tag_o, .cpu_rsp_prio_o, .req_valid_out_o, .req_control_out_o,
  .req_addr_out_o, .req_wdata_out_o, .req_byte_en_out_o, .req_tag_out_o,
  .req_prio_out_o, .req_ready_in_i);
